// ===== verilog/rfs_rx_frame_status.sv
// Receive frame status and byte count registers with the transmit queue command register
// What this block does
// - Status bit 11 set when received TCP checksum is wrong.
// - Status bit 10 set when received UDP checksum is wrong.
// - Status bit 7 set for broadcast destination.
// - Status bit 6 set for multicast destination, broadcast included.
// - Status bit 5 set for unicast destination.
// - Status bit 4 set on MII symbol error during reception.
// - Status bit 3 set when length/type exceeds 1500, clear otherwise.
// - Status bit 2 set above 2000 bytes; frame is never truncated.
// - Status bit 1 set for collision-damaged or prematurely ended frames.
// - Status bit 0 set on CRC error.
// - Runt, too-long, CRC-bad frames reach host only with pass-bad enabled.
// - Byte count register bits 11-0 give frame size, upper bits zero.
// - One status and count entry per frame, readable per frame count.
// - Writing command bit 1 arms an interrupt when requested space frees.
// - Monitor bit self-clears after frame sent; host waits before rewriting.
// - Writing command bit 0 queues one frame; self-clears after it is sent.
// - Status bit 15 set when present frame and status are valid.
`timescale 1ns/1ps
`include "rfs_params.svh"
module rfs_rx_frame_status
   import rfs_pkg::*;
#(
   parameter int SPACE_WIDTH = 13,
   parameter int COUNT_WIDTH = 8
)
(
   input  wire logic                   mclk,
   input  wire logic                   rst,
   input  wire logic                   reg_wr,
   input  wire logic                   reg_rd,
   input  wire logic [7:0]             reg_addr,
   input  wire logic [1:0]             reg_be,
   input  wire logic [15:0]            reg_wdata,
   output      logic [15:0]            reg_rdata,
   input  wire logic                   pass_bad_frame,
   input  wire logic                   rx_frame_end,
   input  wire logic                   tcp_checksum_bad,
   input  wire logic                   udp_checksum_bad,
   input  wire logic [47:0]            dest_addr,
   input  wire logic                   symbol_error,
   input  wire logic [15:0]            length_type,
   input  wire logic [11:0]            rx_byte_count,
   input  wire logic                   collision_or_short,
   input  wire logic                   crc_bad,
   input  wire logic                   rx_frame_release,
   output      logic                   rx_frame_drop,
   output      logic [COUNT_WIDTH-1:0] rx_frame_counter,
   input  wire logic [SPACE_WIDTH-1:0] tx_free_bytes,
   input  wire logic                   tx_frame_taken,
   input  wire logic                   tx_frame_done,
   output      logic                   tx_enqueue_req,
   output      logic                   tx_space_event
);
   // Depth must be a power of two so the entry pointers wrap by themselves
   localparam int ENTRY_DEPTH = `RFS_RX_ENTRIES;
   localparam int PTR_WIDTH   = $clog2(ENTRY_DEPTH);
   rfs_word_type           new_status;
   logic                   new_bad;
   rfs_word_type           entry_status [ENTRY_DEPTH];
   logic [11:0]            entry_count  [ENTRY_DEPTH];
   logic [PTR_WIDTH-1:0]   wr_ptr;
   logic [PTR_WIDTH-1:0]   rd_ptr;
   logic [SPACE_WIDTH-1:0] tx_space_request;
   logic                   manual_enqueue;
   logic                   tx_space_monitor;
   rfs_word_type           next_rdata;

   function automatic logic [15:0] merge_bytes(input logic [15:0] old_v, input logic [15:0] new_v,
                                                 input logic [1:0] be);
      merge_bytes = {be[1] ? new_v[15:8] : old_v[15:8], be[0] ? new_v[7:0] : old_v[7:0]};
   endfunction : merge_bytes

   rfs_status_builder u_builder
   (
      .tcp_checksum_bad   (tcp_checksum_bad),
      .udp_checksum_bad   (udp_checksum_bad),
      .dest_addr          (dest_addr),
      .symbol_error       (symbol_error),
      .length_type        (length_type),
      .rx_byte_count      (rx_byte_count),
      .collision_or_short (collision_or_short),
      .crc_bad            (crc_bad),
      .status_word        (new_status),
      .frame_bad          (new_bad)
   );

   wire logic hit_status = (reg_addr == `RFS_OFF_HDR_STATUS);
   wire logic hit_count  = (reg_addr == `RFS_OFF_BYTE_COUNT);
   wire logic hit_cmd    = (reg_addr == `RFS_OFF_TXQ_CMD);
   wire logic hit_space  = (reg_addr == `RFS_OFF_TX_SPACE_REQ);
   wire logic cmd_write  = reg_wr & hit_cmd & reg_be[0];
   wire logic have_frame     = (rx_frame_counter != '0);
   wire logic rx_frame_valid = have_frame;
   wire logic pop            = rx_frame_release & have_frame;
   wire logic store_full     = (rx_frame_counter == COUNT_WIDTH'(ENTRY_DEPTH)) & ~pop;
   wire logic accept         = rx_frame_end & (~new_bad | pass_bad_frame) & ~store_full;
   wire logic drop           = rx_frame_end & ~accept;
   wire rfs_word_type cur_status = entry_status[rd_ptr];
   wire logic [11:0]  cur_count  = entry_count[rd_ptr];
   wire logic [15:0] space_merged = merge_bytes(16'(tx_space_request), reg_wdata, reg_be);

   rfs_tx_enqueue #(.SPACE_WIDTH(SPACE_WIDTH)) u_tx
   (
      .mclk             (mclk),
      .rst              (rst),
      .cmd_write        (cmd_write),
      .cmd_bits         (reg_wdata[1:0]),
      .tx_space_request (tx_space_request),
      .tx_free_bytes    (tx_free_bytes),
      .tx_frame_taken   (tx_frame_taken),
      .tx_frame_done    (tx_frame_done),
      .manual_enqueue   (manual_enqueue),
      .tx_space_monitor (tx_space_monitor),
      .tx_enqueue_req   (tx_enqueue_req),
      .tx_space_event   (tx_space_event)
   );

   always_comb
   begin
      next_rdata = `RFS_RESET_WORD;
      if (hit_status)
      begin
         next_rdata                 = rx_frame_valid ? cur_status : `RFS_RESET_WORD;
         next_rdata[`RFS_BIT_VALID] = rx_frame_valid;
      end
      else if (hit_count)
      begin
         next_rdata[11:0] = rx_frame_valid ? cur_count : 12'h000;
      end
      else if (hit_cmd)
      begin
         next_rdata[`RFS_CMD_ENQUEUE] = manual_enqueue;
         next_rdata[`RFS_CMD_MONITOR] = tx_space_monitor;
      end
      else if (hit_space)
      begin
         next_rdata[SPACE_WIDTH-1:0] = tx_space_request;
      end
   end

   always_ff @(posedge mclk or posedge rst)
   begin
      if (rst)
      begin
         reg_rdata <= `RFS_RESET_WORD;
      end
      else if (reg_rd)
      begin
         reg_rdata <= next_rdata;
      end
   end

   // Entry store: one status word and byte count per kept frame, oldest at the read pointer
   always_ff @(posedge mclk)
   begin
      if (accept)
      begin
         entry_status[wr_ptr] <= new_status;
         entry_count[wr_ptr]  <= rx_byte_count;
      end
   end

   // Frame counter and entry pointers; a full store with no release in the same cycle withholds further frames
   always_ff @(posedge mclk or posedge rst)
   begin
      if (rst)
      begin
         rx_frame_counter <= '0;
         wr_ptr           <= '0;
         rd_ptr           <= '0;
         rx_frame_drop    <= 1'b0;
         tx_space_request <= '0;
      end
      else
      begin
         rx_frame_drop <= drop;
         if (accept & ~pop)
         begin
            rx_frame_counter <= rx_frame_counter + 1'b1;
         end
         else if (~accept & pop)
         begin
            rx_frame_counter <= rx_frame_counter - 1'b1;
         end
         if (accept)
         begin
            wr_ptr <= wr_ptr + 1'b1;
         end
         if (pop)
         begin
            rd_ptr <= rd_ptr + 1'b1;
         end
         if (reg_wr & hit_space)
         begin
            tx_space_request <= space_merged[SPACE_WIDTH-1:0];
         end
      end
   end
endmodule : rfs_rx_frame_status

// ===== shared/rfs_params.svh
// Register offsets, field positions and limits for the receive status and transmit enqueue block
`ifndef RFS_PARAMS_SVH
`define RFS_PARAMS_SVH
`define RFS_OFF_HDR_STATUS   8'h7C
`define RFS_OFF_BYTE_COUNT   8'h7E
`define RFS_OFF_TXQ_CMD      8'h80
`define RFS_OFF_TX_SPACE_REQ 8'h9E
`define RFS_BIT_VALID        15
`define RFS_BIT_TCP_BAD      11
`define RFS_BIT_UDP_BAD      10
`define RFS_BIT_BCAST        7
`define RFS_BIT_MCAST        6
`define RFS_BIT_UCAST        5
`define RFS_BIT_SYMERR       4
`define RFS_BIT_ETYPE        3
`define RFS_BIT_TOO_LONG     2
`define RFS_BIT_RUNT         1
`define RFS_BIT_CRC          0
`define RFS_CMD_ENQUEUE      0
`define RFS_CMD_MONITOR      1
`define RFS_ISR_SPACE_BIT    6
`define RFS_ETYPE_MIN_LEN    16'd1500
`define RFS_MAX_FRAME_LEN    12'd2000
`define RFS_RESET_WORD       16'h0000
`define RFS_RX_ENTRIES       8
`endif

// ===== shared/rfs_pkg.sv
// Types shared by the receive status and transmit enqueue block
package rfs_pkg;
   typedef enum logic [1:0] {rfs_tx_idle, rfs_tx_queued, rfs_tx_sending} rfs_tx_state_type;
   typedef logic [15:0] rfs_word_type;
endpackage : rfs_pkg

// ===== verilog/rfs_status_builder.sv
// Builds the header status word of a completed received frame
`timescale 1ns/1ps
`include "rfs_params.svh"
module rfs_status_builder
   import rfs_pkg::*;
(
   input  wire logic         tcp_checksum_bad,
   input  wire logic         udp_checksum_bad,
   input  wire logic [47:0]  dest_addr,
   input  wire logic         symbol_error,
   input  wire logic [15:0]  length_type,
   input  wire logic [11:0]  rx_byte_count,
   input  wire logic         collision_or_short,
   input  wire logic         crc_bad,
   output      rfs_word_type status_word,
   output      logic         frame_bad
);
   wire logic is_broadcast    = &dest_addr;
   wire logic is_multicast    = dest_addr[40];
   wire logic is_unicast      = ~dest_addr[40];
   wire logic ethertype_frame = length_type > `RFS_ETYPE_MIN_LEN;
   wire logic frame_too_long  = rx_byte_count > `RFS_MAX_FRAME_LEN;
   wire logic runt_frame      = collision_or_short;
   always_comb
   begin
      status_word                    = `RFS_RESET_WORD;
      status_word[`RFS_BIT_TCP_BAD]  = tcp_checksum_bad;
      status_word[`RFS_BIT_UDP_BAD]  = udp_checksum_bad;
      status_word[`RFS_BIT_BCAST]    = is_broadcast;
      status_word[`RFS_BIT_MCAST]    = is_multicast;
      status_word[`RFS_BIT_UCAST]    = is_unicast;
      status_word[`RFS_BIT_SYMERR]   = symbol_error;
      status_word[`RFS_BIT_ETYPE]    = ethertype_frame;
      status_word[`RFS_BIT_TOO_LONG] = frame_too_long;
      status_word[`RFS_BIT_RUNT]     = runt_frame;
      status_word[`RFS_BIT_CRC]      = crc_bad;
   end
   assign frame_bad = frame_too_long | runt_frame | crc_bad;
endmodule : rfs_status_builder

// ===== verilog/rfs_tx_enqueue.sv
// Transmit command bits: manual enqueue and free-space monitor
`timescale 1ns/1ps
`include "rfs_params.svh"
module rfs_tx_enqueue
   import rfs_pkg::*;
#(
   parameter int SPACE_WIDTH = 13
)
(
   input  wire logic                   mclk,
   input  wire logic                   rst,
   input  wire logic                   cmd_write,
   input  wire logic [1:0]             cmd_bits,
   input  wire logic [SPACE_WIDTH-1:0] tx_space_request,
   input  wire logic [SPACE_WIDTH-1:0] tx_free_bytes,
   input  wire logic                   tx_frame_taken,
   input  wire logic                   tx_frame_done,
   output      logic                   manual_enqueue,
   output      logic                   tx_space_monitor,
   output      logic                   tx_enqueue_req,
   output      logic                   tx_space_event
);
   rfs_tx_state_type state;
   rfs_tx_state_type next_state;
   logic             space_fired;
   wire logic start_enq = cmd_write & cmd_bits[`RFS_CMD_ENQUEUE] & (state == rfs_tx_idle);
   wire logic start_mon = cmd_write & cmd_bits[`RFS_CMD_MONITOR] & ~tx_space_monitor;
   wire logic space_ok  = tx_space_monitor & ~space_fired & (tx_free_bytes >= tx_space_request);
   always_comb
   begin
      next_state = state;
      unique case (state)
         rfs_tx_idle:    if (start_enq) next_state = rfs_tx_queued;
         rfs_tx_queued:  if (tx_frame_taken) next_state = rfs_tx_sending;
         rfs_tx_sending: if (tx_frame_done) next_state = rfs_tx_idle;
      endcase
   end
   assign manual_enqueue = (state != rfs_tx_idle);
   assign tx_enqueue_req = (state == rfs_tx_queued);
   always_ff @(posedge mclk or posedge rst)
   begin
      if (rst)
      begin
         state            <= rfs_tx_idle;
         tx_space_monitor <= 1'b0;
         space_fired      <= 1'b0;
         tx_space_event   <= 1'b0;
      end
      else
      begin
         state          <= next_state;
         tx_space_event <= space_ok;
         if (start_mon)
         begin
            tx_space_monitor <= 1'b1;
            space_fired      <= 1'b0;
         end
         else if (tx_frame_done)
         begin
            tx_space_monitor <= 1'b0;
         end
         if (space_ok)
         begin
            space_fired <= 1'b1;
         end
      end
   end
endmodule : rfs_tx_enqueue

// ===== tb/rfs_rx_frame_status_assertions.sv
// Concurrent checks on the ports of the receive status and transmit enqueue block
`timescale 1ns/1ps
`include "rfs_params.svh"
module rfs_rx_frame_status_checker
   import rfs_pkg::*;
#(
   parameter int SPACE_WIDTH = 13,
   parameter int COUNT_WIDTH = 8
)
(
   input wire logic                   mclk,
   input wire logic                   rst,
   input wire logic                   reg_wr,
   input wire logic                   reg_rd,
   input wire logic                   pass_bad_frame,
   input wire logic                   rx_frame_end,
   input wire logic                   tcp_checksum_bad,
   input wire logic                   udp_checksum_bad,
   input wire logic                   symbol_error,
   input wire logic                   collision_or_short,
   input wire logic                   crc_bad,
   input wire logic                   rx_frame_release,
   input wire logic                   rx_frame_drop,
   input wire logic                   tx_frame_taken,
   input wire logic                   tx_frame_done,
   input wire logic                   tx_enqueue_req,
   input wire logic                   tx_space_event,
   input wire logic [7:0]             reg_addr,
   input wire logic [1:0]             reg_be,
   input wire logic [15:0]            reg_wdata,
   input wire logic [15:0]            reg_rdata,
   input wire logic [15:0]            length_type,
   input wire logic [47:0]            dest_addr,
   input wire logic [11:0]            rx_byte_count,
   input wire logic [COUNT_WIDTH-1:0] rx_frame_counter,
   input wire logic [SPACE_WIDTH-1:0] tx_free_bytes
);
   default clocking cb @(posedge mclk); endclocking
   default disable iff (rst);
   // A frame is kept unless it is bad and not passed, or the entry store is full with no release in the same cycle
   wire logic full = (rx_frame_counter == COUNT_WIDTH'(`RFS_RX_ENTRIES));
   wire logic bad  = crc_bad | collision_or_short | (rx_byte_count > `RFS_MAX_FRAME_LEN);
   wire logic keep = rx_frame_end & (pass_bad_frame | ~bad) & (~full | rx_frame_release);
   sequence s_bad_end; rx_frame_end && !keep; endsequence
   sequence s_pulse; tx_space_event ##1 !tx_space_event; endsequence
   property p_drop; s_bad_end |=> rx_frame_drop; endproperty
   property p_pass; keep |=> !rx_frame_drop; endproperty
   property p_drop_cause; rx_frame_drop |-> $past(rx_frame_end) && !$past(keep); endproperty
   property p_count_up; keep && !rx_frame_release |=> rx_frame_counter == $past(rx_frame_counter) + 1'b1; endproperty
   property p_count_hold; !keep && !rx_frame_release |=> $stable(rx_frame_counter); endproperty
   property p_rdata_hold; !reg_rd |=> $stable(reg_rdata); endproperty
   property p_taken; tx_frame_taken |=> !tx_enqueue_req; endproperty
   property p_enq_cause; $rose(tx_enqueue_req) |-> $past(reg_wr) && $past(reg_addr) == 8'h80 && $past(reg_wdata[0]);
   endproperty
   property p_event_once; tx_space_event |-> s_pulse; endproperty
   property p_empty_status; reg_rd && reg_addr == 8'h7C && rx_frame_counter == '0 |=> reg_rdata == 16'h0000;
   endproperty
   property p_count_upper; reg_rd && reg_addr == 8'h7E |=> reg_rdata[15:12] == 4'h0; endproperty
   a_drop: assert property (p_drop) else $error("bad frame not withheld");
   a_pass: assert property (p_pass) else $error("good frame dropped");
   a_drop_cause: assert property (p_drop_cause) else $error("drop without bad frame end");
   a_count_up: assert property (p_count_up) else $error("frame counter missed a frame");
   a_count_hold: assert property (p_count_hold) else $error("frame counter moved");
   a_rdata_hold: assert property (p_rdata_hold) else $error("read data changed without read");
   a_taken: assert property (p_taken) else $error("enqueue request stays after take");
   a_enq_cause: assert property (p_enq_cause) else $error("enqueue request without command");
   a_event_once: assert property (p_event_once) else $error("space event longer than a pulse");
   a_empty_status: assert property (p_empty_status) else $error("status not zero with no frame held");
   a_count_upper: assert property (p_count_upper) else $error("byte count upper bits not zero");
endmodule : rfs_rx_frame_status_checker

// ===== tb/rfs_host_model.sv
// Host processor model driving the register port
`timescale 1ns/1ps
module rfs_host_model
(
   input  wire logic        mclk,
   input  wire logic [15:0] reg_rdata,
   output      logic        reg_wr,
   output      logic        reg_rd,
   output      logic [7:0]  reg_addr,
   output      logic [1:0]  reg_be,
   output      logic [15:0] reg_wdata
);
   initial
   begin
      {reg_wr, reg_rd, reg_addr, reg_be, reg_wdata} = '0;
   end
   task automatic wr(input logic [7:0] a, input logic [15:0] d);
      @(negedge mclk);
      {reg_wr, reg_addr, reg_be, reg_wdata} = {1'b1, a, 2'b11, d};
      @(negedge mclk);
      {reg_wr, reg_wdata} = {1'b0, ~d};
   endtask : wr
   // Whole 16-bit reads, so the low byte is never taken after the high one
   task automatic rd(input logic [7:0] a, output logic [15:0] d);
      @(negedge mclk);
      {reg_rd, reg_addr} = {1'b1, a};
      @(negedge mclk);
      reg_rd = 1'b0;
      d = reg_rdata;
   endtask : rd
endmodule : rfs_host_model

// ===== tb/rfs_rx_frame_status_tb.sv
// Testbench for the receive status and transmit enqueue block
`timescale 1ns/1ps
`include "rfs_params.svh"
`define CHK(n, e, a) begin total_checks++; if ((a) !== (e)) begin error_cnt++; $display("mismatch %s exp %h got %h", n, e, a); end end
module rfs_rx_frame_status_tb;
   logic        mclk = 0, rst = 1, pass_bad_frame = 1, rx_frame_end = 0, tcp_checksum_bad = 0;
   logic        udp_checksum_bad = 0, symbol_error = 0, collision_or_short = 0, crc_bad = 0;
   logic        rx_frame_release = 0, tx_frame_taken = 0, tx_frame_done = 0;
   logic        reg_wr, reg_rd, rx_frame_drop, tx_enqueue_req, tx_space_event;
   logic [7:0]  reg_addr, rx_frame_counter;
   logic [1:0]  reg_be;
   logic [15:0] reg_wdata, reg_rdata, v, length_type = 0;
   logic [47:0] dest_addr = 0;
   logic [11:0] rx_byte_count = 0;
   logic [12:0] tx_free_bytes = 0;
   logic [7:0]  adr[4] = '{8'h7C, 8'h7E, 8'h80, 8'h7A};
   int          error_cnt = 0, total_checks = 0;
   integer      n = 0;
   rfs_rx_frame_status #(.SPACE_WIDTH(13), .COUNT_WIDTH(8)) i_rfs_rx_frame_status (.mclk, .rst, .reg_wr,
      .reg_rd, .reg_addr, .reg_be, .reg_wdata, .reg_rdata, .pass_bad_frame, .rx_frame_end, .tcp_checksum_bad,
      .udp_checksum_bad, .dest_addr, .symbol_error, .length_type, .rx_byte_count, .collision_or_short, .crc_bad,
      .rx_frame_release, .rx_frame_drop, .rx_frame_counter, .tx_free_bytes, .tx_frame_taken, .tx_frame_done,
      .tx_enqueue_req, .tx_space_event);
   rfs_host_model i_rfs_host_model (.mclk, .reg_rdata, .reg_wr, .reg_rd, .reg_addr, .reg_be, .reg_wdata);
   initial
   begin
      forever #5 mclk = ~mclk;
   end
   task automatic wrap_up;
      $display("checks %0d errors %0d", total_checks, error_cnt);
      if (error_cnt == 0 && total_checks > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask : wrap_up
   task automatic pulse(ref logic s);
      @(negedge mclk);
      s = 1'b1;
      @(negedge mclk);
      s = 1'b0;
   endtask : pulse
   // Frame inputs go to their inverse once the end pulse is over
   task automatic rx(input logic [4:0] f, input logic [47:0] da, input logic [15:0] lt, input logic [11:0] bc);
      @(negedge mclk);
      {crc_bad, collision_or_short, symbol_error, udp_checksum_bad, tcp_checksum_bad} = f;
      {dest_addr, length_type, rx_byte_count, rx_frame_end} = {da, lt, bc, 1'b1};
      @(negedge mclk);
      {crc_bad, collision_or_short, symbol_error, udp_checksum_bad, tcp_checksum_bad} = ~f;
      {dest_addr, length_type, rx_byte_count, rx_frame_end} = {~da, ~lt, ~bc, 1'b0};
   endtask : rx
   function automatic logic [15:0] st(input logic [4:0] f, input logic [47:0] da, input logic [15:0] lt,
                                      input logic [11:0] bc);
      st = {4'h8, f[0], f[1], 2'h0, &da, da[40], ~da[40], f[2], lt > 16'd1500, bc > 12'd2000, f[3], f[4]};
   endfunction : st
   task automatic frame(input logic [4:0] f, input logic [47:0] da, input logic [15:0] lt, input logic [11:0] bc);
      rx(f, da, lt, bc);
      `CHK("counter", 8'h01, rx_frame_counter)
      repeat (2)
      begin
         i_rfs_host_model.rd(8'h7C, v);
         `CHK("status", st(f, da, lt, bc), v)
      end
      i_rfs_host_model.rd(8'h7E, v);
      `CHK("count", {4'h0, bc}, v)
      pulse(rx_frame_release);
      `CHK("counter", 8'h00, rx_frame_counter)
   endtask : frame
   initial
   begin
      repeat (4) @(posedge mclk);
      @(negedge mclk) rst = 0;
      foreach (adr[i])
      begin
         i_rfs_host_model.rd(adr[i], v);
         `CHK("reset read", 16'h0000, v)
      end
      frame(5'b00001, 48'h0200_0000_0001, 16'd1501, 12'd64);
      frame(5'b00110, 48'hFFFF_FFFF_FFFF, 16'd1500, 12'd2000);
      frame(5'b11000, 48'h0100_5E00_0001, 16'h0800, 12'd2001);
      pass_bad_frame = 0;
      rx(5'b10000, 48'h0200_0000_0002, 16'h0800, 12'd80);
      `CHK("drop", 1'b1, rx_frame_drop)
      rx(5'b01000, 48'h0200_0000_0002, 16'h0800, 12'd80);
      `CHK("runt drop", 1'b1, rx_frame_drop)
      rx(5'b00000, 48'h0200_0000_0002, 16'h0800, 12'd2001);
      `CHK("long drop", 1'b1, rx_frame_drop)
      `CHK("counter", 8'h00, rx_frame_counter)
      i_rfs_host_model.rd(8'h7C, v);
      `CHK("empty status", 16'h0000, v)
      rx(5'b00000, 48'h0200_0000_0003, 16'h0800, 12'd100);
      rx(5'b00000, 48'h0200_0000_0004, 16'h0800, 12'd200);
      `CHK("counter", 8'h02, rx_frame_counter)
      i_rfs_host_model.rd(8'h7E, v);
      `CHK("first count", 16'd100, v)
      pulse(rx_frame_release);
      i_rfs_host_model.rd(8'h7E, v);
      `CHK("second count", 16'd200, v)
      pulse(rx_frame_release);
      repeat (`RFS_RX_ENTRIES + 1) rx(5'b00000, 48'h0200_0000_0005, 16'h0800, 12'd60);
      `CHK("full drop", 1'b1, rx_frame_drop)
      `CHK("full counter", 8'(`RFS_RX_ENTRIES), rx_frame_counter)
      i_rfs_host_model.rd(8'h7E, v);
      `CHK("full head count", 16'd60, v)
      repeat (`RFS_RX_ENTRIES) pulse(rx_frame_release);
      `CHK("drained", 8'h00, rx_frame_counter)
      i_rfs_host_model.wr(8'h80, 16'h0001);
      `CHK("enqueue req", 1'b1, tx_enqueue_req)
      pulse(tx_frame_taken);
      i_rfs_host_model.wr(8'h80, 16'h0001);
      `CHK("second enqueue", 1'b0, tx_enqueue_req)
      i_rfs_host_model.rd(8'h80, v);
      `CHK("enqueue bit", 16'h0001, v)
      pulse(tx_frame_done);
      i_rfs_host_model.rd(8'h80, v);
      `CHK("enqueue clear", 16'h0000, v)
      tx_free_bytes = 13'd50;
      i_rfs_host_model.wr(8'h9E, 16'd100);
      i_rfs_host_model.wr(8'h80, 16'h0002);
      i_rfs_host_model.rd(8'h9E, v);
      `CHK("space request", 16'd100, v)
      repeat (5) @(negedge mclk) n += tx_space_event;
      `CHK("early events", 0, n)
      tx_free_bytes = 13'd100;
      repeat (8) @(negedge mclk) n += tx_space_event;
      `CHK("space events", 1, n)
      i_rfs_host_model.rd(8'h80, v);
      `CHK("monitor bit", 16'h0002, v)
      pulse(tx_frame_done);
      i_rfs_host_model.rd(8'h80, v);
      `CHK("monitor clear", 16'h0000, v)
      wrap_up();
   end
   initial
   begin
      #100000;
      error_cnt++;
      wrap_up();
   end
endmodule : rfs_rx_frame_status_tb
bind rfs_rx_frame_status rfs_rx_frame_status_checker #(.SPACE_WIDTH(SPACE_WIDTH), .COUNT_WIDTH(COUNT_WIDTH))
   i_rfs_rx_frame_status_checker (.mclk, .rst, .reg_wr, .reg_rd, .pass_bad_frame, .rx_frame_end, .tcp_checksum_bad,
   .udp_checksum_bad, .symbol_error, .collision_or_short, .crc_bad, .rx_frame_release, .rx_frame_drop,
   .tx_frame_taken, .tx_frame_done, .tx_enqueue_req, .tx_space_event, .reg_addr, .reg_be, .reg_wdata, .reg_rdata,
   .length_type, .dest_addr, .rx_byte_count, .rx_frame_counter, .tx_free_bytes);
